// ==== hdl/osc_regs.sv ====
// What this block does
// - internal control bit 7 enables internal oscillator; resets to zero.
// - internal control bit 6 reads one only while oscillator runs at frequency.
// - trim register bit 7 enables spread-spectrum dithering; resets to zero.
// - seven-bit trim field resets to a per-part factory code.
// - higher trim code lowers frequency, about one percent per step.
// - mode field bits 6:4 selects off, cmos, cmos/2, rc, cap, xtal, xtal/2.
// - external control bit 7 reads one when external oscillator in an rc, cap or xtal mode runs stable.
// - valid flag reads zero in both external cmos clock modes.
// - external control bit 3 reads zero; software writes zero.
// - bias field bits 2:0 accepts all codes, resets to zero with mode.
`timescale 1ns/1ps

module osc_regs
    import osc_pkg::*;
#(
    parameter logic [6:0] FACTORY_TRIM = osc_pkg::OSC_TRIM_DEF,
    parameter logic [5:0] INT_RSV_INIT = osc_pkg::OSC_INT_RSV_DEF
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst_b,
    // register bus
    input  wire osc_pkg::osc_bus_s  bus,
    output logic [7:0]              rdata,
    // analog status
    input  wire logic               intFreqLock,
    input  wire logic               extStable,
    // analog control
    output osc_pkg::osc_ctrl_s      ctrl
);
    import osc_pkg::*;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rstSync1_q;
    logic rstSync2_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rstSync1_q <= 1'b0;
            rstSync2_q <= 1'b0;
        end else begin
            rstSync1_q <= 1'b1;
            rstSync2_q <= rstSync1_q;
        end
    end

    wire logic rstInt_b = rstSync2_q;

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    function automatic osc_ext_kind_e kind_of(input logic [2:0] m);
        case (m)
            OSC_MODE_CMOS, OSC_MODE_CMOS_D2: kind_of = OSC_EXT_CMOS;
            OSC_MODE_RC, OSC_MODE_CAP,
            OSC_MODE_XTAL, OSC_MODE_XTAL_D2: kind_of = OSC_EXT_ANALOG;
            default:                         kind_of = OSC_EXT_OFF;
        endcase
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic       intOn_q,  intOn_d;
    logic [5:0] intRsv_q, intRsv_d;
    logic       sse_q,    sse_d;
    logic [6:0] trim_q,   trim_d;
    logic [2:0] mode_q,   mode_d;
    logic [2:0] bias_q,   bias_d;
    logic       rdy_q,    rdy_d;
    logic       vld_q,    vld_d;
    logic [7:0] rdata_q,  rdata_d;

    always_comb begin
        intOn_d      = intOn_q;
        intRsv_d     = intRsv_q;
        sse_d        = sse_q;
        trim_d       = trim_q;
        mode_d       = mode_q;
        bias_d       = bias_q;
        rdata_d      = rdata_q;
        if (bus.wr) begin
            case (bus.addr)
                OSC_ADDR_INT: begin
                    intOn_d  = bus.wdata[OSC_INT_ON_BIT];
                    intRsv_d = bus.wdata[5:0];
                end
                OSC_ADDR_TRIM: begin
                    sse_d  = bus.wdata[OSC_TRIM_SSE_BIT];
                    trim_d = bus.wdata[6:0];
                end
                OSC_ADDR_EXT: begin
                    mode_d = bus.wdata[OSC_EXT_MODE_LSB +: 3];
                    bias_d = bus.wdata[OSC_EXT_BIAS_LSB +: 3];
                end
                default: begin
                end
            endcase
        end
        // ready only while enabled and the oscillator reports lock
        rdy_d = intOn_q && intFreqLock;
        // cmos modes never report valid
        vld_d = (kind_of(mode_q) == OSC_EXT_ANALOG) && extStable;
        if (bus.rd) begin
            case (bus.addr)
                OSC_ADDR_INT:  rdata_d = {intOn_q, rdy_q, intRsv_q};
                OSC_ADDR_TRIM: rdata_d = {sse_q, trim_q};
                OSC_ADDR_EXT:  rdata_d = {vld_q, mode_q, 1'b0, bias_q};
                default:       rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstInt_b) begin
        if (!rstInt_b) begin
            intOn_q      <= OSC_INT_ON_RST;
            // per-part codes are held from reset onwards, so the oscillator
            // never runs on a generic trim
            intRsv_q     <= INT_RSV_INIT;
            sse_q        <= OSC_SSE_RST;
            trim_q       <= FACTORY_TRIM;
            mode_q       <= OSC_MODE_RST;
            bias_q       <= OSC_BIAS_RST;
            rdy_q        <= 1'b0;
            vld_q        <= 1'b0;
            rdata_q      <= 8'h00;
        end else begin
            intOn_q      <= intOn_d;
            intRsv_q     <= intRsv_d;
            sse_q        <= sse_d;
            trim_q       <= trim_d;
            mode_q       <= mode_d;
            bias_q       <= bias_d;
            rdy_q        <= rdy_d;
            vld_q        <= vld_d;
            rdata_q      <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata          = rdata_q;
    assign ctrl.intOn     = intOn_q;
    assign ctrl.ditherOn  = sse_q;
    assign ctrl.trim      = trim_q;
    assign ctrl.extMode   = mode_q;
    assign ctrl.extBias   = bias_q;
    assign ctrl.extDivTwo = (mode_q == OSC_MODE_CMOS_D2) || (mode_q == OSC_MODE_XTAL_D2);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    ready_needs_on_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        rdy_q |-> $past(intOn_q))
        else $error("ready without enable");

    ready_off_zero_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        !intOn_q |=> !rdy_q)
        else $error("ready while disabled");

    ready_tracks_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        ##1 (rdy_q == $past(intOn_q && intFreqLock)))
        else $error("ready wrong");

    enable_write_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (bus.wr && bus.addr == OSC_ADDR_INT) |=> (intOn_q == $past(bus.wdata[7])))
        else $error("enable not written");

    enable_hold_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        !(bus.wr && bus.addr == OSC_ADDR_INT) |=> $stable(intOn_q))
        else $error("enable changed without write");

    int_read_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (bus.rd && bus.addr == OSC_ADDR_INT) |=> (rdata[7:6] == {$past(intOn_q), $past(rdy_q)}))
        else $error("int read wrong");

    dither_write_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (bus.wr && bus.addr == OSC_ADDR_TRIM) |=> (ctrl.ditherOn == $past(bus.wdata[7])))
        else $error("dither not written");

    trim_write_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (bus.wr && bus.addr == OSC_ADDR_TRIM) |=> (ctrl.trim == $past(bus.wdata[6:0])))
        else $error("trim not written");

    trim_hold_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        !(bus.wr && bus.addr == OSC_ADDR_TRIM) |=> $stable(ctrl.trim))
        else $error("trim changed without write");

    trim_read_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (bus.rd && bus.addr == OSC_ADDR_TRIM) |=> (rdata == {$past(sse_q), $past(trim_q)}))
        else $error("trim read wrong");

    ext_write_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (bus.wr && bus.addr == OSC_ADDR_EXT) |=> (ctrl.extMode == $past(bus.wdata[6:4])
        && ctrl.extBias == $past(bus.wdata[2:0])))
        else $error("ext not written");

    bias_hold_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        !(bus.wr && bus.addr == OSC_ADDR_EXT) |=> $stable(ctrl.extBias))
        else $error("bias changed without write");

    div_two_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        ctrl.extDivTwo == (ctrl.extMode[1:0] == 2'b11))
        else $error("divide by two wrong");

    cmos_no_valid_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (mode_q[2:1] == 2'b01) [*2] |-> !vld_q)
        else $error("valid in cmos mode");

    off_no_valid_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (mode_q[2:1] == 2'b00) [*2] |-> !vld_q)
        else $error("valid while disabled");

    valid_tracks_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        ##1 (vld_q == $past(mode_q[2] && extStable)))
        else $error("valid wrong");

    ext_read_a: assert property (@(posedge clock) disable iff (!rstInt_b)
        (bus.rd && bus.addr == OSC_ADDR_EXT) |=> (rdata[3] == 1'b0 &&
        rdata[6:4] == $past(mode_q) && rdata[2:0] == $past(bias_q)))
        else $error("ext read wrong");

endmodule

// ==== hdl/osc_pkg.sv ====
package osc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OSC_ADDR_EXT  = 8'hB1;
    localparam logic [7:0] OSC_ADDR_INT  = 8'hB2;
    localparam logic [7:0] OSC_ADDR_TRIM = 8'hB3;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int OSC_INT_ON_BIT    = 7;
    localparam int OSC_INT_RDY_BIT   = 6;
    localparam int OSC_TRIM_SSE_BIT  = 7;
    localparam int OSC_EXT_VLD_BIT   = 7;
    localparam int OSC_EXT_MODE_LSB  = 4;
    localparam int OSC_EXT_RSV_BIT   = 3;
    localparam int OSC_EXT_BIAS_LSB  = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic       OSC_INT_ON_RST   = 1'b0;
    localparam logic       OSC_SSE_RST      = 1'b0;
    localparam logic [2:0] OSC_MODE_RST     = 3'h0;
    localparam logic [2:0] OSC_BIAS_RST     = 3'h0;
    localparam logic [5:0] OSC_INT_RSV_DEF  = 6'h00;
    localparam logic [6:0] OSC_TRIM_DEF     = 7'h40;

    // ------------------------------------------------------------
    // external mode codes
    // ------------------------------------------------------------
    localparam logic [2:0] OSC_MODE_CMOS    = 3'h2;
    localparam logic [2:0] OSC_MODE_CMOS_D2 = 3'h3;
    localparam logic [2:0] OSC_MODE_RC      = 3'h4;
    localparam logic [2:0] OSC_MODE_CAP     = 3'h5;
    localparam logic [2:0] OSC_MODE_XTAL    = 3'h6;
    localparam logic [2:0] OSC_MODE_XTAL_D2 = 3'h7;

    typedef enum logic [1:0] {
        OSC_EXT_OFF,
        OSC_EXT_CMOS,
        OSC_EXT_ANALOG
    } osc_ext_kind_e;

    // bus request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } osc_bus_s;

    // controls to analog oscillators
    typedef struct packed {
        logic       intOn;
        logic       ditherOn;
        logic [6:0] trim;
        logic [2:0] extMode;
        logic [2:0] extBias;
        logic       extDivTwo;
    } osc_ctrl_s;

endpackage

// ==== dv/osc_regs_bench.sv ====
`timescale 1ns/1ps

module osc_regs_bench;
    import osc_pkg::*;

    typedef struct {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       lock;
        logic       stable;
        logic [7:0] expRd;
    } osc_row_s;

    logic       clock;
    logic       rst_b;
    osc_bus_s   bus;
    logic [7:0] rdata;
    logic       intFreqLock;
    logic       extStable;
    osc_ctrl_s  ctrl;
    int         nFail;
    int         checksDone;
    int         cycles;
    osc_row_s   rows[$];
    logic [7:0] rv;
    logic [7:0] wd;

    osc_regs #(
        .FACTORY_TRIM (7'h2A),
        .INT_RSV_INIT (6'h15)
    ) dut_u (
        .clock       (clock),
        .rst_b       (rst_b),
        .bus         (bus),
        .rdata       (rdata),
        .intFreqLock (intFreqLock),
        .extStable   (extStable),
        .ctrl        (ctrl)
    );

    // ------------------------------------------------------------
    // clock, timeout, helpers
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 1000) begin
            nFail++;
            endSim();
        end
    end

    task automatic endSim;
        $display("checks %0d, mismatches %0d", checksDone, nFail);
        if (nFail == 0 && checksDone > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checksDone++;
        if (got !== exp) begin
            nFail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // bus tasks are entered just after a rising edge and leave one idle
    // edge behind them, so back-to-back calls never retoggle a strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        bus.wr = 1'b1;
        bus.addr = a;
        bus.wdata = d;
        @(posedge clock);
        #1 bus.wr = 1'b0;
        @(posedge clock);
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        bus.rd = 1'b1;
        bus.addr = a;
        @(posedge clock);
        #1 bus.rd = 1'b0;
        d = rdata;
        @(posedge clock);
        #1;
    endtask

    task automatic do_reset;
        rst_b = 1'b0;
        repeat (2) @(posedge clock);
        #1 rst_b = 1'b1;
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic chk_reset;
        rd_reg(OSC_ADDR_EXT, rv);
        chk(rv, 8'h00);
        rd_reg(OSC_ADDR_INT, rv);
        chk(rv, 8'h15);
        rd_reg(OSC_ADDR_TRIM, rv);
        chk(rv, 8'h2A);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        bus = '0;
        rst_b = 1'b0;
        intFreqLock = 1'b1;
        extStable = 1'b1;
        nFail = 0;
        checksDone = 0;
        cycles = 0;
        for (int m = 0; m < 8; m++) begin
            rows.push_back('{OSC_ADDR_EXT, {1'b1, 3'(m), 1'b0, 3'(7 - m)}, 1'b0, 1'b1,
                             {m[2], 3'(m), 1'b0, 3'(7 - m)}});
        end
        rows.push_back('{OSC_ADDR_EXT, 8'h60, 1'b0, 1'b0, 8'h60});
        // int rows only give the enable bit; reserved bits stay at their reset code
        rows.push_back('{OSC_ADDR_INT, 8'h80, 1'b1, 1'b0, 8'hD5});
        rows.push_back('{OSC_ADDR_INT, 8'h3F, 1'b1, 1'b0, 8'h15});
        rows.push_back('{OSC_ADDR_INT, 8'hFF, 1'b0, 1'b0, 8'h95});
        rows.push_back('{OSC_ADDR_INT, 8'hFF, 1'b1, 1'b0, 8'hD5});
        rows.push_back('{OSC_ADDR_TRIM, 8'h85, 1'b0, 1'b0, 8'h85});
        rows.push_back('{OSC_ADDR_TRIM, 8'h7F, 1'b0, 1'b0, 8'h7F});
        rows.push_back('{8'hB4, 8'h55, 1'b0, 1'b0, 8'h00});
        do_reset();
        chk_reset();
        foreach (rows[i]) begin
            wd = rows[i].wdata;
            // enable changes go through read-modify-write
            if (rows[i].addr == OSC_ADDR_INT) begin
                rd_reg(OSC_ADDR_INT, rv);
                wd = {rows[i].wdata[7], rv[6:0]};
            end
            wr_reg(rows[i].addr, wd);
            intFreqLock = rows[i].lock;
            extStable = rows[i].stable;
            repeat (2) @(posedge clock);
            #1 rd_reg(rows[i].addr, rv);
            chk(rv, rows[i].expRd);
            case (rows[i].addr)
                OSC_ADDR_EXT: chk({ctrl.extDivTwo, ctrl.extMode, 1'b0, ctrl.extBias},
                    {&wd[5:4], wd[6:4], 1'b0, wd[2:0]});
                OSC_ADDR_INT: chk({7'h00, ctrl.intOn}, {7'h00, rows[i].wdata[7]});
                OSC_ADDR_TRIM: chk({ctrl.ditherOn, ctrl.trim}, rows[i].wdata);
                default: ;
            endcase
        end
        // mid-run reset with the lock input high: ready must stay low
        intFreqLock = 1'b1;
        do_reset();
        chk_reset();
        // write and read of one register in the same cycle returns the old value
        bus.wr = 1'b1;
        bus.rd = 1'b1;
        bus.addr = OSC_ADDR_TRIM;
        bus.wdata = 8'h11;
        @(posedge clock);
        #1 bus.wr = 1'b0;
        bus.rd = 1'b0;
        chk(rdata, 8'h2A);
        @(posedge clock);
        #1 rd_reg(OSC_ADDR_TRIM, rv);
        chk(rv, 8'h11);
        // rc start-up: the valid flag is polled after the switch to this source
        extStable = 1'b0;
        wr_reg(OSC_ADDR_EXT, 8'h44);
        rd_reg(OSC_ADDR_EXT, rv);
        chk(rv, 8'h44);
        extStable = 1'b1;
        rv = 8'h00;
        for (int k = 0; k < 4 && !rv[7]; k++) rd_reg(OSC_ADDR_EXT, rv);
        chk(rv, 8'hC4);
        endSim();
    end
endmodule
